// >>> hdl/cts_regs.svh
// constants of the can time-stamp timer: offsets, fields, reset values
// assumes a 32-bit register port with byte addresses on a 100 MHz clock
//
// Contract
// RULE1: counter advances once per prescaler period, only while capture enable is set
// RULE2: prescaler setting all ones advances the counter every 65535 clocks
// RULE3: prescaler setting zero advances the counter on every clock
// RULE4: capture enable low holds counter and prescaler count still
// RULE5: any timer register write clears prescaler count, setting keeps written value
// RULE6: counter is 16-bit read-write upper half of timer register, reset zero
// RULE7: prescaler setting is 16-bit read-write lower half, reset zero
// RULE8: counter wraps from all ones to zero with no other effect
`ifndef CTS_REGS_SVH
`define CTS_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define CTS_OFF_TIMER 8'h00
`define CTS_OFF_CTRL 8'h04
`define CTS_OFF_STAMP 8'h08
`define CTS_OFF_PRECNT 8'h0c

////////////////////////////////////////////////////////////////////////////////
// field positions
`define CTS_TIMER_COUNT_LSB 16
`define CTS_TIMER_COUNT_MSB 31
`define CTS_TIMER_PRE_LSB 0
`define CTS_TIMER_PRE_MSB 15
`define CTS_CTRL_CAPEN_BIT 20
`define CTS_STAMP_VALID_BIT 16

////////////////////////////////////////////////////////////////////////////////
// reset values
`define CTS_RST_COUNT 16'h0000
`define CTS_RST_PRESET 16'h0000
`define CTS_RST_CAPEN 1'b0
`define CTS_RST_RDATA 32'h0000_0000

`endif

// >>> hdl/cts_pkg.sv
// types of the can time-stamp timer
// assumes cts_regs.svh holds every number; this file holds only types
package cts_pkg;

  // width of counter, prescaler and stamp
  typedef logic [15:0] cts_word_t;

  // which register an address selects
  typedef enum logic [2:0] {
    CTS_SEL_TIMER,
    CTS_SEL_CTRL,
    CTS_SEL_STAMP,
    CTS_SEL_PRECNT,
    CTS_SEL_NONE
  } cts_sel_t;

endpackage : cts_pkg

// >>> hdl/cts_prescaler.sv
// prescaler of the time-stamp timer: one tick per programmed period
// assumes clear and run come from the register logic in the same clock
`timescale 1ns/1ps
`include "cts_regs.svh"

module cts_prescaler #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic clear,
  input wire logic [WIDTH-1:0] period,
  // status
  output logic tick,
  output logic [WIDTH-1:0] count
);

  ////////////////////////////////////////////////////////////////////////////
  // last count of a period; zero and one both mean every clock
  function automatic logic [WIDTH-1:0] last_of(input logic [WIDTH-1:0] p);
    logic [WIDTH-1:0] r;
    r = (p == '0) ? '0 : WIDTH'(p - 1'b1);
    return r;
  endfunction : last_of

  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  wire logic [WIDTH-1:0] last = last_of(period);
  // >= so a setting lowered mid-period ends the period at once
  wire logic at_end = (cnt_q >= last);

  // tick only while running; held count while stopped
  assign tick = run & at_end; // RULE1 RULE2 RULE3
  assign count = cnt_q;

  // clear has priority over counting
  always_comb begin
    if (clear) begin
      cnt_d = '0; // RULE5
    end else if (!run) begin
      cnt_d = cnt_q; // RULE4
    end else if (at_end) begin
      cnt_d = '0;
    end else begin
      cnt_d = WIDTH'(cnt_q + 1'b1);
    end
  end

  // count register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : cts_prescaler

// >>> hdl/cts_timer.sv
// can time-stamp timer: 16-bit counter behind a 16-bit prescaler
// assumes a plain register port, one-cycle strobes, read data a cycle later
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "cts_regs.svh"

module cts_timer #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  // frame event from the can controller
  input wire logic frame_stb,
  // timer state for the controller
  output logic [WIDTH-1:0] timestamp_count,
  output logic timestamp_capture_enable,
  output logic timestamp_tick
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  // map an address to a register select
  function automatic cts_pkg::cts_sel_t decode(input logic [7:0] a);
    cts_pkg::cts_sel_t s;
    s = cts_pkg::CTS_SEL_NONE;
    if (a == `CTS_OFF_TIMER) begin
      s = cts_pkg::CTS_SEL_TIMER;
    end else if (a == `CTS_OFF_CTRL) begin
      s = cts_pkg::CTS_SEL_CTRL;
    end else if (a == `CTS_OFF_STAMP) begin
      s = cts_pkg::CTS_SEL_STAMP;
    end else if (a == `CTS_OFF_PRECNT) begin
      s = cts_pkg::CTS_SEL_PRECNT;
    end
    return s;
  endfunction : decode

  cts_pkg::cts_sel_t sel;
  assign sel = decode(addr);
  wire logic wr_timer = wr_stb & (sel == cts_pkg::CTS_SEL_TIMER);
  wire logic wr_ctrl = wr_stb & (sel == cts_pkg::CTS_SEL_CTRL);
  wire logic rd_stamp = rd_stb & (sel == cts_pkg::CTS_SEL_STAMP);

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic [WIDTH-1:0] preset_q;
  logic [WIDTH-1:0] preset_d;
  logic capen_q;
  logic capen_d;
  logic [WIDTH-1:0] stamp_q;
  logic [WIDTH-1:0] stamp_d;
  logic stamp_vld_q;
  logic stamp_vld_d;
  logic tick_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // prescaler outputs
  logic pre_tick;
  logic [WIDTH-1:0] pre_count;

  ////////////////////////////////////////////////////////////////////////////
  // prescaler: runs only with capture enable, cleared by a timer write

  cts_prescaler #(
    .WIDTH(WIDTH)
  ) u_pre (
    .clk(clk),
    .rst(rst),
    .run(capen_q), // RULE1 RULE4
    .clear(wr_timer), // RULE5
    .period(preset_q),
    .tick(pre_tick),
    .count(pre_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next values of the timer register

  // written fields split out of the write data
  wire logic [WIDTH-1:0] wr_count =
    wdata[`CTS_TIMER_COUNT_LSB +: WIDTH]; // RULE6
  wire logic [WIDTH-1:0] wr_preset =
    wdata[`CTS_TIMER_PRE_LSB +: WIDTH]; // RULE7

  // software write beats a tick in the same cycle; the written value stands
  // natural overflow wraps all ones to zero
  assign count_d = wr_timer ? wr_count
                 : pre_tick ? WIDTH'(count_q + 1'b1) // RULE1 RULE8
                 : count_q; // RULE4

  // setting changes only by software, never by the prescaler
  assign preset_d = wr_timer ? wr_preset : preset_q; // RULE5 RULE7

  // capture enable bit sits where the controller keeps it
  assign capen_d = wr_ctrl ? wdata[`CTS_CTRL_CAPEN_BIT] : capen_q;

  ////////////////////////////////////////////////////////////////////////////
  // frame stamp: latch the counter on a frame while stamping is enabled

  // set wins over the clear by read, so a stamp is never lost
  assign stamp_d = (frame_stb & capen_q) ? count_q : stamp_q;
  assign stamp_vld_d = (frame_stb & capen_q) ? 1'b1
                     : rd_stamp ? 1'b0
                     : stamp_vld_q;

  ////////////////////////////////////////////////////////////////////////////
  // read mux: data only in the cycle after the strobe, zero otherwise

  wire logic [31:0] rd_timer_word = {count_q, preset_q}; // RULE6 RULE7
  wire logic [31:0] rd_ctrl_word =
    32'(capen_q) << `CTS_CTRL_CAPEN_BIT;
  wire logic [31:0] rd_stamp_word =
    (32'(stamp_vld_q) << `CTS_STAMP_VALID_BIT) | 32'(stamp_q);
  wire logic [31:0] rd_pre_word = 32'(pre_count);

  // unmapped addresses read as zero
  always_comb begin
    rdata_d = `CTS_RST_RDATA;
    if (rd_stb) begin
      unique case (sel)
        cts_pkg::CTS_SEL_TIMER: rdata_d = rd_timer_word;
        cts_pkg::CTS_SEL_CTRL: rdata_d = rd_ctrl_word;
        cts_pkg::CTS_SEL_STAMP: rdata_d = rd_stamp_word;
        cts_pkg::CTS_SEL_PRECNT: rdata_d = rd_pre_word;
        cts_pkg::CTS_SEL_NONE: rdata_d = `CTS_RST_RDATA;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer registers; zero at power-on

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= `CTS_RST_COUNT; // RULE6
      preset_q <= `CTS_RST_PRESET; // RULE7
    end else begin
      count_q <= count_d;
      preset_q <= preset_d;
    end
  end

  // control and stamp registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      capen_q <= `CTS_RST_CAPEN;
      stamp_q <= `CTS_RST_COUNT;
      stamp_vld_q <= 1'b0;
    end else begin
      capen_q <= capen_d;
      stamp_q <= stamp_d;
      stamp_vld_q <= stamp_vld_d;
    end
  end

  // read data and tick outputs, registered so outputs leave from flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= `CTS_RST_RDATA;
      tick_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      tick_q <= pre_tick & ~wr_timer;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // count output is the register itself, so it lags nothing
  assign timestamp_count = count_q;
  assign timestamp_capture_enable = capen_q;
  // tick shows in the same cycle as the stepped count, and not at all when a timer write wins
  assign timestamp_tick = tick_q;
  assign rdata = rdata_q;

endmodule : cts_timer

// >>> bench/cts_timer_sva.sv
// checker of the time-stamp timer ports
// assumes one-cycle strobes and read data in the next cycle
`timescale 1ns/1ps
module cts_timer_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched ports
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [31:0] rdata,
  input wire logic [15:0] timestamp_count,
  input wire logic timestamp_capture_enable
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  wire wt = wr_stb && addr == 8'h00;
  wire [15:0] wr_cnt = wdata[31:16];
  wire en = timestamp_capture_enable;
  logic [15:0] pre_q;
  logic [15:0] gap_q;
  // setting 0 counts as a period of one
  wire [15:0] last = (pre_q == 16'h0000) ? 16'h0000 : pre_q - 16'h0001;
  ////////////////////////////////////////////////////////////////////////////
  // phase model: write restarts it, a pause keeps it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_q <= 16'h0000;
      gap_q <= 16'h0000;
    end else if (wt) begin
      pre_q <= wdata[15:0];
      gap_q <= 16'h0000;
    end else if (en) begin
      gap_q <= (gap_q == last) ? 16'h0000 : gap_q + 16'h0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_wait;
    en && !wt && gap_q != last |=> $stable(timestamp_count);
  endproperty
  a_wait: assert property (p_wait) else $error("count moved early");
  property p_step;
    en && !wt && gap_q == last |=> timestamp_count == $past(timestamp_count) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("count step missed");
  property p_wrap;
    en && !wt && gap_q == last && timestamp_count == 16'hffff |=> timestamp_count == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap");
  property p_hold;
    !en && !wt |=> $stable(timestamp_count);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved paused");
  property p_wr;
    wt |=> timestamp_count == $past(wr_cnt);
  endproperty
  a_wr: assert property (p_wr) else $error("write not taken");
  property p_rd;
    rd_stb && addr == 8'h00 |=> rdata[31:16] == $past(timestamp_count);
  endproperty
  a_rd: assert property (p_rd) else $error("count read wrong");
  property p_rdpre;
    rd_stb && addr == 8'h00 |=> rdata[15:0] == pre_q;
  endproperty
  a_rdpre: assert property (p_rdpre) else $error("setting read wrong");
  property p_idle;
    !rd_stb |=> rdata == 32'h0000_0000;
  endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  c_wrap: cover property (timestamp_count == 16'hffff ##1 timestamp_count == 16'h0000);
  c_wr: cover property (wt && en);
  c_rd: cover property (rd_stb && addr == 8'h00 && en);
endmodule : cts_timer_sva

bind cts_timer cts_timer_sva u_sva (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .timestamp_count(timestamp_count),
  .timestamp_capture_enable(timestamp_capture_enable));

// >>> bench/cts_timer_bench.sv
// bench of the time-stamp timer: register calls with expected values
// assumes cts_timer and its checker are compiled first
`timescale 1ns/1ps
module cts_timer_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic frame_stb = 1'b0;
  logic [31:0] rdata;
  logic [15:0] ts_count;
  logic ts_capen;
  logic ts_tick;
  int bad_count = 0;
  int total_checks = 0;
  // 100 mhz clock
  always #5 clk = ~clk;
  cts_timer u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .frame_stb(frame_stb), .timestamp_count(ts_count),
    .timestamp_capture_enable(ts_capen), .timestamp_tick(ts_tick));
  //////////////////////////////////////////////////////////////////////////////
  // one comparison; case equality so an unknown counts as a mismatch
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask : chk
  // each call takes two cycles, so count math below is exact
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), e, rdata);
    @(posedge clk);
  endtask : rd
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  //////////////////////////////////////////////////////////////////////////////
  // main sequence; the last test pulses the frame input and looks at the outputs
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h00, 32'h0000_0000);
    rd(8'h04, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    wr(8'h00, 32'h1234_0003);
    repeat (10) @(posedge clk);
    rd(8'h00, 32'h1234_0003);
    $display("test reset and pause done");
    wr(8'h04, 32'h0010_0000);
    wr(8'h00, 32'h0000_0003);
    repeat (8) @(posedge clk);
    rd(8'h00, 32'h0003_0003);
    wr(8'h00, 32'h0005_0003);
    wr(8'h00, 32'h0005_0003);
    rd(8'h00, 32'h0005_0003);
    wr(8'h00, 32'hfffe_0000);
    @(posedge clk);
    rd(8'h00, 32'h0000_0000);
    $display("test short periods done");
    wr(8'h00, 32'h0007_ffff);
    repeat (65533) @(posedge clk);
    rd(8'h00, 32'h0007_ffff);
    rd(8'h00, 32'h0008_ffff);
    wr(8'h04, 32'h0000_0000);
    repeat (5) @(posedge clk);
    rd(8'h00, 32'h0008_ffff);
    rd(8'h0c, 32'h0000_0004);
    $display("test long period done");
    wr(8'h00, 32'h0040_0004);
    rd(8'h0c, 32'h0000_0000);
    // a frame while paused is refused
    frame_stb <= 1'b1;
    @(posedge clk);
    frame_stb <= 1'b0;
    rd(8'h08, 32'h0000_0000);
    wr(8'h04, 32'h0010_0000);
    // stamp taken while running, counter steps one cycle after the read data arrives
    frame_stb <= 1'b1;
    @(posedge clk);
    frame_stb <= 1'b0;
    rd(8'h08, 32'h0001_0040);
    #1;
    chk("tick", 32'h0000_0001, 32'(ts_tick));
    chk("count", 32'h0000_0041, 32'(ts_count));
    chk("enable", 32'h0000_0001, 32'(ts_capen));
    @(posedge clk);
    wr(8'h04, 32'h0000_0000);
    rd(8'h08, 32'h0000_0040);
    rd(8'h0c, 32'h0000_0002);
    #1;
    chk("tick", 32'h0000_0000, 32'(ts_tick));
    chk("count", 32'h0000_0041, 32'(ts_count));
    $display("test stamp and outputs done");
    report_and_stop();
  end
  // watchdog: the run needs about 0.66 ms
  initial begin
    #800_000;
    bad_count++;
    report_and_stop();
  end
endmodule : cts_timer_bench
